/* inc/clock_gear_cfg.svh */
`ifndef CLOCK_GEAR_CFG_SVH
`define CLOCK_GEAR_CFG_SVH
// register indices on the plain port (byte address = index * 4)
`define ADDR_SYS_CLOCK_CTRL 4'h0
`define ADDR_OSC_CTRL 4'h1
`define ADDR_WAKE_CTRL 4'h2
`define ADDR_IRQ_STATUS 4'h3
`define ADDR_IRQ_MASK 4'h4
// system clock control fields
`define GEAR_LSB 0
`define GEAR_FULL 3'h0
`define GEAR_DIV16 3'h4
// oscillator control fields
`define PLL_EN_BIT 0
`define PLL_MULT 4'h8
// wake field positions, line 5 base; line n adds 8*(n-5)
`define WAKE_EN_LSB 8
`define WAKE_SEEN_LSB 10
`define WAKE_SEL_LSB 12
`define WAKE_LINE_STRIDE 8
`define WAKE_CTRL_RESET 32'h0000_0000
// gear change settle time
`define GEAR_DELAY_NS 80
`define GEAR_DELAY_CYC ((`GEAR_DELAY_NS + 9) / 10)
`endif

/* inc/clock_gear_pkg.sv */
package clock_gear_pkg;
   // active condition codes of a wake line
   typedef enum logic [2:0] {
      WAKE_LOW = 3'b000,
      WAKE_HIGH = 3'b001,
      WAKE_FALL = 3'b010,
      WAKE_RISE = 3'b011,
      WAKE_BOTH = 3'b100
   } wake_sel_t;
   // plain register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage

/* core/clock_gear_and_wakeup_detect.sv */
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "clock_gear_cfg.svh"
module clock_gear_and_wakeup_detect (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire clock_gear_pkg::reg_req_t req,
   output logic [31:0] rdata,
   input wire logic [2:0] external_irq_line,
   output logic [3:0] clk_mult,
   output logic [4:0] clk_div,
   output logic gear_busy,
   output logic [2:0] wake_req,
   output logic irq
);
   import clock_gear_pkg::*;

   logic [2:0] gear_sel_q; // gear written by software
   logic [2:0] gear_act_q; // gear in force
   logic [3:0] gear_cnt_q; // settle countdown
   logic pll_en_q; // pll enable
   logic [2:0] sel_q [3]; // per-line condition select
   logic [1:0] seen_q [3]; // per-line detected condition
   logic [2:0] en_q; // per-line enable
   logic [2:0] sync1_q, sync2_q, prev_q; // pin synchronisers
   logic [2:0] hit; // condition met this cycle
   logic [2:0] rise, fall;
   logic [2:0] stat_q, mask_q; // sticky events and mask
   logic [31:0] wake_word;
   logic [31:0] rdata_d;
   logic wr_gear, wr_wake;

   assign wr_gear = req.wr && req.addr == `ADDR_SYS_CLOCK_CTRL;
   assign wr_wake = req.wr && req.addr == `ADDR_WAKE_CTRL;

   // gear register and delayed switch; old ratio holds while settling
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         gear_sel_q <= `GEAR_FULL;
         gear_act_q <= `GEAR_FULL;
         gear_cnt_q <= 4'h0;
      end else if (wr_gear) begin
         // divide-by-16 with pll off is left to software
         gear_sel_q <= req.wdata[`GEAR_LSB +: 3];
         gear_cnt_q <= 4'(`GEAR_DELAY_CYC);
      end else if (gear_cnt_q == 4'h1) begin
         gear_act_q <= gear_sel_q;
         gear_cnt_q <= 4'h0;
      end else if (gear_cnt_q != 4'h0) begin
         gear_cnt_q <= gear_cnt_q - 4'h1;
      end
   end

   // pll enable, off after reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pll_en_q <= 1'b0;
      end else if (req.wr && req.addr == `ADDR_OSC_CTRL) begin
         pll_en_q <= req.wdata[`PLL_EN_BIT];
      end
   end

   // clock path settings driven to the clock generator cells
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         clk_mult <= 4'h1;
         clk_div <= 5'h01;
         gear_busy <= 1'b0;
      end else begin
         clk_mult <= pll_en_q ? `PLL_MULT : 4'h1;
         // codes above 1/16 are treated as 1/16
         clk_div <= (gear_act_q > `GEAR_DIV16) ? 5'h10 :
            5'(5'h01 << gear_act_q);
         gear_busy <= gear_cnt_q != 4'h0;
      end
   end

   // two-flop synchronisers, then an edge history flop
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         prev_q <= 3'h0;
      end else begin
         sync1_q <= external_irq_line;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;

   // condition match per line
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         unique case (sel_q[i])
            WAKE_LOW: hit[i] = ~sync2_q[i];
            WAKE_HIGH: hit[i] = sync2_q[i];
            WAKE_FALL: hit[i] = fall[i];
            WAKE_RISE: hit[i] = rise[i];
            WAKE_BOTH: hit[i] = rise[i] | fall[i];
            default: hit[i] = 1'b0; // prohibited codes never match
         endcase
      end
   end

   // wake control fields; seen field records the last edge kind while the line is enabled
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < 3; i++) begin
            sel_q[i] <= 3'h0;
            seen_q[i] <= 2'h0;
         end
         en_q <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (wr_wake) begin
               sel_q[i] <= req.wdata[`WAKE_SEL_LSB
                  + `WAKE_LINE_STRIDE * i +: 3];
               en_q[i] <= req.wdata[`WAKE_EN_LSB
                  + `WAKE_LINE_STRIDE * i];
            end
            if (en_q[i] && (rise[i] || fall[i])) begin
               seen_q[i] <= {fall[i], rise[i]};
            end
         end
      end
   end

   // wake request out, gated by enable
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wake_req <= 3'h0;
      end else begin
         wake_req <= hit & en_q;
      end
   end

   // sticky status: set wins over write-one clear
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stat_q <= 3'h0;
         mask_q <= 3'h0;
      end else begin
         if (req.wr && req.addr == `ADDR_IRQ_MASK) begin
            mask_q <= req.wdata[2:0];
         end
         if (req.wr && req.addr == `ADDR_IRQ_STATUS) begin
            stat_q <= (stat_q & ~req.wdata[2:0]) | (hit & en_q);
         end else begin
            stat_q <= stat_q | (hit & en_q);
         end
      end
   end

   // level interrupt from a flop
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_q & mask_q);
      end
   end

   // wake register image; reserved bits read zero
   always_comb begin
      wake_word = `WAKE_CTRL_RESET;
      for (int i = 0; i < 3; i++) begin
         wake_word[`WAKE_SEL_LSB + `WAKE_LINE_STRIDE * i +: 3] = sel_q[i];
         wake_word[`WAKE_SEEN_LSB + `WAKE_LINE_STRIDE * i +: 2] =
            seen_q[i];
         wake_word[`WAKE_EN_LSB + `WAKE_LINE_STRIDE * i] = en_q[i];
      end
   end

   // read mux; unmapped reads return zero
   always_comb begin
      unique case (req.addr)
         `ADDR_SYS_CLOCK_CTRL: rdata_d = {29'h0, gear_sel_q};
         `ADDR_OSC_CTRL: rdata_d = {31'h0, pll_en_q};
         `ADDR_WAKE_CTRL: rdata_d = wake_word;
         `ADDR_IRQ_STATUS: rdata_d = {29'h0, stat_q};
         `ADDR_IRQ_MASK: rdata_d = {29'h0, mask_q};
         default: rdata_d = 32'h0;
      endcase
   end

   // read data valid only the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata <= 32'h0;
      end else begin
         rdata <= req.rd ? rdata_d : 32'h0;
      end
   end

   // helper for the settle check: edges since the last gear write,
   // saturating so a long idle stretch cannot wrap back into range
   logic [4:0] settle_q;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         settle_q <= 5'h0;
      end else if (wr_gear) begin
         // a rewrite mid-settle restarts the count, as the divider does
         settle_q <= 5'h1;
      end else if (settle_q != 5'h0 && settle_q != 5'h1f) begin
         settle_q <= settle_q + 5'h1;
      end
   end

   // gear change step: busy is up and the old ratio is still in force
   sequence s_gear_hold;
      gear_busy && $stable(clk_div);
   endsequence

   // pin step on line five: the synchronised level goes low to high
   sequence s_pin_rise0;
      !sync2_q[0] ##1 sync2_q[0];
   endsequence

   // busy is registered from the countdown, so it shows one edge late
   a_gear_delay: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_gear |=> ##1 s_gear_hold)
      else $error("gear switched without delay");
   a_gear_settle: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(gear_busy) |-> settle_q == 5'(`GEAR_DELAY_CYC + 2))
      else $error("gear settle length wrong");
   a_div_change: assert property (@(posedge mclk) disable iff (sys_rst)
      $changed(clk_div) |-> $past(gear_busy))
      else $error("divider moved outside a settle");
   a_div_ratio: assert property (@(posedge mclk) disable iff (sys_rst)
      $onehot(clk_div))
      else $error("divider not a power of two");
   a_pll_off: assert property (@(posedge mclk) disable iff (sys_rst)
      !pll_en_q |=> clk_mult == 4'h1)
      else $error("multiplier active with pll off");
   a_reset_pll: assert property (@(posedge mclk)
      sys_rst |=> !pll_en_q && gear_act_q == `GEAR_FULL)
      else $error("reset left pll or gear set");
   a_seen_fall: assert property (@(posedge mclk) disable iff (sys_rst)
      en_q[0] && fall[0] |=> seen_q[0] == 2'b10)
      else $error("falling edge not recorded");
   a_rise_seen: assert property (@(posedge mclk) disable iff (sys_rst)
      s_pin_rise0 ##0 en_q[0] |=> seen_q[0] == 2'b01)
      else $error("synchronised rise not recorded");
   a_seen_read: assert property (@(posedge mclk) disable iff (sys_rst)
      req.rd && req.addr == `ADDR_WAKE_CTRL
      |=> rdata[27:26] == $past(seen_q[2]))
      else $error("line seven seen field misread");
   a_low_match: assert property (@(posedge mclk) disable iff (sys_rst)
      en_q[1] && sel_q[1] == WAKE_LOW && !sync2_q[1] |=> wake_req[1])
      else $error("low level missed");
   a_fall_only: assert property (@(posedge mclk) disable iff (sys_rst)
      en_q[0] && sel_q[0] == WAKE_FALL && rise[0] |=> !wake_req[0])
      else $error("rise matched falling code");
   a_both_match: assert property (@(posedge mclk) disable iff (sys_rst)
      en_q[2] && sel_q[2] == WAKE_BOTH && (rise[2] || fall[2])
      |=> wake_req[2] && stat_q[2])
      else $error("edge missed in both-edge mode");
   a_stat_set: assert property (@(posedge mclk) disable iff (sys_rst)
      |(hit & en_q) |=> |stat_q)
      else $error("wake event not latched");
   a_line6_map: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_wake |=> en_q[1] == $past(req.wdata[16])
      && sel_q[1] == $past(req.wdata[22:20]))
      else $error("line six fields misplaced");
   a_line5_map: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_wake |=> en_q[0] == $past(req.wdata[8])
      && sel_q[0] == $past(req.wdata[14:12]))
      else $error("line five fields misplaced");
   a_wake_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      !en_q[0] |=> !wake_req[0])
      else $error("disabled line raised wake");
   a_pll_mult: assert property (@(posedge mclk) disable iff (sys_rst)
      pll_en_q |=> clk_mult == 4'h8)
      else $error("pll multiplier wrong");
   a_seen_rise: assert property (@(posedge mclk) disable iff (sys_rst)
      en_q[1] && rise[1] |=> seen_q[1] == 2'b01)
      else $error("rising edge not recorded");
   a_high_match: assert property (@(posedge mclk) disable iff (sys_rst)
      en_q[2] && sel_q[2] == WAKE_HIGH && sync2_q[2] |=> wake_req[2])
      else $error("high level missed");
   a_sync_delay: assert property (@(posedge mclk) disable iff (sys_rst)
      sync2_q == $past(external_irq_line, 2) || $past(sys_rst)
      || $past(sys_rst, 2))
      else $error("synchroniser depth wrong");
   a_reset_gear: assert property (@(posedge mclk)
      $past(sys_rst) && sys_rst |-> clk_div == 5'h01 && clk_mult == 4'h1)
      else $error("reset clock not undivided");
   a_field_map: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_wake |=> en_q[2] == $past(req.wdata[24]))
      else $error("line seven enable misplaced");
endmodule

/* tb/irq_pin_model.sv */
`timescale 1ns/10ps
// far side: the three external interrupt pins, always driven solid
module irq_pin_model (
   input wire logic clk,
   output logic [2:0] pins
);
   // lines start low so the synchronisers flush clean during reset
   initial pins = 3'h0;
   // a new level lands just after an edge, as a board driver would
   task automatic drive(input logic [2:0] v);
      @(posedge clk);
      pins <= v;
   endtask
endmodule

/* tb/tb_clock_gear_and_wakeup_detect.sv */
`timescale 1ns/10ps
`include "clock_gear_cfg.svh"
module tb_clock_gear_and_wakeup_detect;
   import clock_gear_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   reg_req_t req = '0;
   logic [31:0] rdata;
   logic [31:0] d;
   logic [2:0] pins;
   logic [2:0] wake_req;
   logic [3:0] clk_mult;
   logic [4:0] clk_div;
   logic gear_busy;
   logic irq;
   int error_cnt = 0;
   int samples_checked = 0;
   // 100 mhz system clock
   always #5 mclk = ~mclk;
   clock_gear_and_wakeup_detect i_clock_gear_and_wakeup_detect (
      .mclk(mclk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
      .external_irq_line(pins), .clk_mult(clk_mult), .clk_div(clk_div),
      .gear_busy(gear_busy), .wake_req(wake_req), .irq(irq));
   irq_pin_model i_irq_pin_model (.clk(mclk), .pins(pins));
   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge mclk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic finish_test;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // wake condition of code c for a pin moving from o to n
   function automatic logic hit(int c, logic o, logic n);
      return (c == 0 && !n) || (c == 1 && n) ||
         (o != n && ((c == 2 && !n) || (c == 3 && n) || c == 4));
   endfunction
   // cut a hang short well past the expected run length
   initial begin
      #300000;
      error_cnt++;
      finish_test;
   end
   initial begin
      logic [2:0] st;
      int sh;
      logic [31:0] lo;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      #1 chk(32'(clk_div), 32'h1);
      chk(32'(clk_mult), 32'h1);
      rd(`ADDR_OSC_CTRL, d);
      chk(d, 32'h0);
      rd(`ADDR_WAKE_CTRL, d);
      chk(d, `WAKE_CTRL_RESET);
      rd(4'h5, d);
      chk(d, 32'h0);
      // pll first: 1/16 is only legal with the multiplier running
      wr(`ADDR_OSC_CTRL, 32'h1);
      wait_cyc(2);
      chk(32'(clk_mult), 32'(`PLL_MULT));
      for (int i = 1; i < 6; i++) begin
         wr(`ADDR_SYS_CLOCK_CTRL, 32'(i % 5));
         // busy follows the countdown by one edge
         wait_cyc(1);
         chk(32'(clk_div), 32'(1 << (i - 1)));
         chk({31'h0, gear_busy}, 32'h1);
         for (int k = 0; k < 30 && gear_busy !== 1'b0; k++) wait_cyc(1);
         wait_cyc(1);
         chk(32'(clk_div), 32'(1 << (i % 5)));
      end
      wr(`ADDR_IRQ_MASK, 32'h7);
      lo = 32'h0;
      // every code on every line, from both idle levels
      for (int n = 0; n < 3; n++) begin
         for (int c = 0; c < 5; c++) begin
            for (int p = 0; p < 2; p++) begin
               sh = `WAKE_LINE_STRIDE * n;
               i_irq_pin_model.drive(3'(p * 7));
               wait_cyc(4);
               d = (32'(c) << (`WAKE_SEL_LSB + sh)) |
                  (32'h1 << (`WAKE_EN_LSB + sh));
               wr(`ADDR_WAKE_CTRL, d);
               wr(`ADDR_IRQ_STATUS, 32'h7);
               wait_cyc(5);
               st = 3'(hit(c, p[0], p[0])) << n;
               rd(`ADDR_IRQ_STATUS, d);
               chk(d, 32'(st));
               i_irq_pin_model.drive(3'((1 - p) * 7));
               wait_cyc(5);
               st = st | (3'(hit(c, p[0], !p[0])) << n);
               rd(`ADDR_IRQ_STATUS, d);
               chk(d, 32'(st));
               chk(32'(wake_req), 32'(3'(hit(c, !p[0], !p[0])) << n));
               chk({31'h0, irq}, 32'(st != 3'h0));
               rd(`ADDR_WAKE_CTRL, d);
               chk(d, (32'(c) << (`WAKE_SEL_LSB + sh)) |
                  (32'h1 << (`WAKE_EN_LSB + sh)) |
                  (32'(p ? 2'b10 : 2'b01) << (`WAKE_SEEN_LSB + sh)) |
                  lo);
            end
         end
         // line n ended on a falling edge; its seen field keeps that
         lo = lo | (32'h2 << (`WAKE_SEEN_LSB + sh));
      end
      // low-level code on idle-low pins would fire if the gate leaked
      wr(`ADDR_WAKE_CTRL, 32'h0);
      wr(`ADDR_IRQ_STATUS, 32'h7);
      wait_cyc(5);
      rd(`ADDR_IRQ_STATUS, d);
      chk(d, 32'h0);
      chk(32'(wake_req), 32'h0);
      wr(`ADDR_WAKE_CTRL, 32'h1 << `WAKE_EN_LSB);
      wr(`ADDR_IRQ_MASK, 32'h0);
      wait_cyc(5);
      chk({31'h0, irq}, 32'h0);
      wr(`ADDR_IRQ_MASK, 32'h1);
      wait_cyc(3);
      chk({31'h0, irq}, 32'h1);
      finish_test;
   end
endmodule
